// *** rtl/tick_timer_pkg.sv ***
// Purpose: shared constants and types of the periodic tick timer
// Assumes: register index times four is the byte address on the bus
// Notes: all registers are eight bits wide in the low byte of a word
package tick_timer_pkg;

  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CLOCK_SOURCE = 6'h07;
  localparam logic [5:0] IDX_TICK_CONTROL = 6'h10;
  localparam logic [5:0] IDX_TICK_SYNC_STATUS = 6'h11;
  localparam logic [5:0] IDX_TICK_IRQ_ENABLE = 6'h12;
  localparam logic [5:0] IDX_TICK_IRQ_FLAGS = 6'h13;
  localparam logic [5:0] IDX_TICK_DEBUG_CONTROL = 6'h15;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_POS = 0;
  localparam int PERIOD_LSB = 3;
  localparam int PERIOD_MSB = 6;
  localparam int BUSY_POS = 0;
  localparam int EVENT_POS = 0;
  localparam int DEBUG_RUN_POS = 0;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] PERIOD_OFF = 4'h0;
  localparam logic [3:0] PERIOD_LONGEST = 4'he;
  localparam logic [3:0] PERIOD_RESERVED = 4'hf;
  localparam logic [14:0] PRESCALE_FULL = 15'h7fff;
  localparam logic [1:0] SYNC_EDGES = 2'h2;
  localparam logic [1:0] SRC_INT32K = 2'h0;
  localparam logic [1:0] SRC_INT1K = 2'h1;
  localparam logic [1:0] SRC_CRYSTAL = 2'h2;
  localparam logic [1:0] SRC_EXT_PIN = 2'h3;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef struct packed {
    logic [3:0] period;
    logic enable;
  } tick_ctrl_t;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic sel_prev;
    logic [1:0] src;
    tick_ctrl_t pend;
    tick_ctrl_t act;
    logic busy;
    logic [1:0] scnt;
    logic ie;
    logic flag;
    logic dbg_run;
    logic [14:0] cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } tick_state_t;

endpackage : tick_timer_pkg

// *** rtl/periodic_tick_timer.sv ***
// Purpose: periodic tick timer counting a slow real-time clock, with APB registers
// Assumes: slow clock sources arrive as pins and are sampled on pclk
// Notes: the slow clock must be well below half of pclk to be seen edge by edge
//
// Register access over APB was left to the implementer.

// Overview of operation
// - period code 0 none, 1..14 gives 4 to 32768 slow cycles, 15 reserved
// - timer counts and ticks only while control enable bit is one
// - busy bit reads one while a control write is synchronizing
// - interrupt enable bit gates the flag onto the request
// - flag is set each time the selected interval elapses
// - writing one clears the flag, writing zero leaves it
// - debug halt with debug run zero freezes the timer
// - debug run one keeps the timer running during debug halt
// - two-bit source picks 32k, 1k, crystal or external clock pin
// - control writes take effect after two slow clock edges
module periodic_tick_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clk_int32k,
  input wire logic clk_int1k,
  input wire logic clk_crystal,
  input wire logic clk_ext_pin,
  input wire logic debug_halt,
  output logic irq
);

  tick_timer_pkg::tick_state_t q, d;

  logic sel_clk;
  logic rtc_edge;
  logic run;
  logic [14:0] mask;
  logic period_valid;
  logic tick_event;
  logic access;
  logic wr;
  logic [5:0] idx;
  logic mapped;

  // ----------------------------------------------------------------
  // slow clock selection and edge detection
  // ----------------------------------------------------------------
  // source clock mux
  always_comb begin
    unique case (q.src)
      tick_timer_pkg::SRC_INT32K: sel_clk = q.sync2[0];
      tick_timer_pkg::SRC_INT1K: sel_clk = q.sync2[1];
      tick_timer_pkg::SRC_CRYSTAL: sel_clk = q.sync2[2];
      tick_timer_pkg::SRC_EXT_PIN: sel_clk = q.sync2[3];
    endcase
  end

  assign rtc_edge = sel_clk & ~q.sel_prev;

  assign run = q.act.enable & ~(debug_halt & ~q.dbg_run);

  assign period_valid = (q.act.period != tick_timer_pkg::PERIOD_OFF) &&
                        (q.act.period != tick_timer_pkg::PERIOD_RESERVED);
  assign mask = tick_timer_pkg::PRESCALE_FULL >>
                (tick_timer_pkg::PERIOD_LONGEST - q.act.period);
  assign tick_event = run & rtc_edge & period_valid & ((q.cnt & mask) == mask);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign idx = paddr[7:2];
  assign access = psel & penable & q.pready;
  assign wr = access & pwrite;
  assign mapped = (idx == tick_timer_pkg::IDX_CLOCK_SOURCE) ||
                  (idx == tick_timer_pkg::IDX_TICK_CONTROL) ||
                  (idx == tick_timer_pkg::IDX_TICK_SYNC_STATUS) ||
                  (idx == tick_timer_pkg::IDX_TICK_IRQ_ENABLE) ||
                  (idx == tick_timer_pkg::IDX_TICK_IRQ_FLAGS) ||
                  (idx == tick_timer_pkg::IDX_TICK_DEBUG_CONTROL);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.sync1 = {clk_ext_pin, clk_crystal, clk_int1k, clk_int32k};
    d.sync2 = q.sync1;
    d.sel_prev = sel_clk;

    if (!q.act.enable) begin
      d.cnt = '0;
    end else if (run && rtc_edge) begin
      d.cnt = q.cnt + 15'h0001;
    end

    // apply pending control after two slow edges
    if (q.busy && rtc_edge) begin
      if (q.scnt == tick_timer_pkg::SYNC_EDGES - 2'h1) begin
        d.act = q.pend;
        d.busy = 1'b0;
        d.scnt = 2'h0;
      end else begin
        d.scnt = q.scnt + 2'h1;
      end
    end

    // one wait state: answer prepared in first access cycle
    d.pready = psel & penable & ~q.pready;
    d.pslverr = psel & penable & ~q.pready & ~mapped;
    if (psel && penable && !q.pready) begin
      d.prdata = '0;
      unique case (idx)
        tick_timer_pkg::IDX_CLOCK_SOURCE: d.prdata[1:0] = q.src;
        tick_timer_pkg::IDX_TICK_CONTROL: begin
          d.prdata[tick_timer_pkg::PERIOD_MSB:tick_timer_pkg::PERIOD_LSB] = q.pend.period;
          d.prdata[tick_timer_pkg::ENABLE_POS] = q.pend.enable;
        end
        tick_timer_pkg::IDX_TICK_SYNC_STATUS: d.prdata[tick_timer_pkg::BUSY_POS] = q.busy;
        tick_timer_pkg::IDX_TICK_IRQ_ENABLE: d.prdata[tick_timer_pkg::EVENT_POS] = q.ie;
        tick_timer_pkg::IDX_TICK_IRQ_FLAGS: d.prdata[tick_timer_pkg::EVENT_POS] = q.flag;
        tick_timer_pkg::IDX_TICK_DEBUG_CONTROL:
          d.prdata[tick_timer_pkg::DEBUG_RUN_POS] = q.dbg_run;
        default: d.prdata = '0;
      endcase
    end

    if (wr) begin
      unique case (idx)
        tick_timer_pkg::IDX_CLOCK_SOURCE: d.src = pwdata[1:0];
        // control write starts a sync; a rewrite restarts it
        tick_timer_pkg::IDX_TICK_CONTROL: begin
          d.pend.period = pwdata[tick_timer_pkg::PERIOD_MSB:tick_timer_pkg::PERIOD_LSB];
          d.pend.enable = pwdata[tick_timer_pkg::ENABLE_POS];
          d.busy = 1'b1;
          d.scnt = 2'h0;
        end
        tick_timer_pkg::IDX_TICK_IRQ_ENABLE: d.ie = pwdata[tick_timer_pkg::EVENT_POS];
        tick_timer_pkg::IDX_TICK_DEBUG_CONTROL:
          d.dbg_run = pwdata[tick_timer_pkg::DEBUG_RUN_POS];
        default: d.src = d.src;
      endcase
    end

    d.flag = (q.flag & ~(wr && idx == tick_timer_pkg::IDX_TICK_IRQ_FLAGS &&
                         pwdata[tick_timer_pkg::EVENT_POS])) | tick_event;

    d.irq = d.flag & d.ie;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_no_tick_off_codes;
    @(posedge pclk) disable iff (!presetn)
      (q.act.period == tick_timer_pkg::PERIOD_OFF ||
       q.act.period == tick_timer_pkg::PERIOD_RESERVED) |-> !tick_event;
  endproperty
  a_no_tick_off_codes: assert property (p_no_tick_off_codes)
    else $error("tick event with off or reserved period");

  property p_disabled_silent;
    @(posedge pclk) disable iff (!presetn)
      !q.act.enable |=> (q.cnt == 15'h0000) && !tick_event;
  endproperty
  a_disabled_silent: assert property (p_disabled_silent)
    else $error("disabled timer counts or ticks");

  property p_busy_on_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == tick_timer_pkg::IDX_TICK_CONTROL) |=> q.busy;
  endproperty
  a_busy_on_write: assert property (p_busy_on_write)
    else $error("busy not set after control write");

  property p_no_irq_without_enable;
    @(posedge pclk) disable iff (!presetn)
      !q.ie |-> !q.irq;
  endproperty
  a_no_irq_without_enable: assert property (p_no_irq_without_enable)
    else $error("irq while interrupt disabled");

  property p_event_sets_flag;
    @(posedge pclk) disable iff (!presetn)
      tick_event |=> q.flag;
  endproperty
  a_event_sets_flag: assert property (p_event_sets_flag)
    else $error("tick event did not set flag");

  property p_write_one_clears;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == tick_timer_pkg::IDX_TICK_IRQ_FLAGS && !tick_event) |=>
        (q.flag == ($past(q.flag) & ~$past(pwdata[0])));
  endproperty
  a_write_one_clears: assert property (p_write_one_clears)
    else $error("flag write one clear misbehaved");

  property p_halt_freezes;
    @(posedge pclk) disable iff (!presetn)
      (debug_halt && !q.dbg_run && q.act.enable) |=> $stable(q.cnt);
  endproperty
  a_halt_freezes: assert property (p_halt_freezes)
    else $error("counter moved during debug halt");

  property p_debug_run_counts;
    @(posedge pclk) disable iff (!presetn)
      (debug_halt && q.dbg_run && q.act.enable && rtc_edge) |=>
        (q.cnt == $past(q.cnt) + 15'h0001);
  endproperty
  a_debug_run_counts: assert property (p_debug_run_counts)
    else $error("counter stalled with debug run set");

  property p_sync_two_edges;
    @(posedge pclk) disable iff (!presetn)
      $fell(q.busy) |-> $past(rtc_edge) && ($past(q.scnt) == 2'h1);
  endproperty
  a_sync_two_edges: assert property (p_sync_two_edges)
    else $error("control applied before two slow edges");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      q.irq == (q.flag && q.ie);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq does not follow flag and enable");

endmodule : periodic_tick_timer

// *** tb/tb_periodic_tick_timer.sv ***
// Purpose: self-checking bench of the periodic tick timer over apb
// Assumes: slow clock toggles every 8 pclk, only on the pins switched on
// Notes: small period codes keep the run short; long codes follow the same doubling
module tb_periodic_tick_timer;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // clocks, pins and design
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic debug_halt = 1'b0;
  logic slow = 1'b0;
  logic [3:0] pins_on = 4'h0;
  logic [3:0] pins;
  logic [2:0] div_q = 3'h0;
  logic [31:0] rdat;
  logic rerr;
  int edges = 0;
  int e0;
  int bad_count = 0;
  int samples_checked = 0;

  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    div_q <= div_q + 3'h1;
    if (div_q == 3'h7) slow <= ~slow;
  end
  always @(posedge slow) edges++;
  // unselected pins stand still so a wrong source choice shows as no ticks
  assign pins = pins_on & {4{slow}};

  periodic_tick_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_int32k(pins[0]), .clk_int1k(pins[1]), .clk_crystal(pins[2]),
    .clk_ext_pin(pins[3]), .debug_halt(debug_halt), .irq(irq));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("pready", 32'h1, 32'h0);
  endtask : apb

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input logic eerr);
    apb(1'b0, idx, 32'h0);
    chk("prdata", exp, rdat);
    chk("pslverr", {31'h0, eerr}, {31'h0, rerr});
  endtask : rd

  task automatic wait_busy();
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, tick_timer_pkg::IDX_TICK_SYNC_STATUS, 32'h0);
      if (rdat[0] === 1'b0) break;
    end
    chk("busy", 32'h0, rdat);
  endtask : wait_busy

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk("irq", 32'h1, {31'h0, irq});
  endtask : wait_irq

  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end

  initial begin
    logic [5:0] regs [6];
    regs = '{6'h07, 6'h10, 6'h11, 6'h12, 6'h13, 6'h15};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 32'h0, 1'b0);
    rd(6'h3f, 32'h0, 1'b1);
    apb(1'b1, tick_timer_pkg::IDX_TICK_SYNC_STATUS, 32'hff);
    rd(tick_timer_pkg::IDX_TICK_SYNC_STATUS, 32'h0, 1'b0);
    // one source per pass, period code grows with it
    for (int s = 0; s < 4; s++) begin
      pins_on <= 4'h1 << s;
      apb(1'b1, tick_timer_pkg::IDX_CLOCK_SOURCE, s);
      apb(1'b1, tick_timer_pkg::IDX_TICK_IRQ_ENABLE, 32'h1);
      apb(1'b1, tick_timer_pkg::IDX_TICK_CONTROL, ((s + 1) << 3) | 1);
      rd(tick_timer_pkg::IDX_TICK_CONTROL, ((s + 1) << 3) | 1, 1'b0);
      rd(tick_timer_pkg::IDX_TICK_SYNC_STATUS, 32'h1, 1'b0);
      wait_busy();
      wait_irq();
      e0 = edges;
      apb(1'b1, tick_timer_pkg::IDX_TICK_IRQ_FLAGS, 32'h1);
      rd(tick_timer_pkg::IDX_TICK_IRQ_FLAGS, 32'h0, 1'b0);
      wait_irq();
      chk("interval", 2 ** (s + 2), edges - e0);
      apb(1'b1, tick_timer_pkg::IDX_TICK_CONTROL, 32'h0);
      wait_busy();
      apb(1'b1, tick_timer_pkg::IDX_TICK_IRQ_FLAGS, 32'h1);
    end
    apb(1'b1, tick_timer_pkg::IDX_TICK_IRQ_ENABLE, 32'h0);
    apb(1'b1, tick_timer_pkg::IDX_TICK_CONTROL, 32'h09);
    wait_busy();
    repeat (200) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(tick_timer_pkg::IDX_TICK_IRQ_FLAGS, 32'h1, 1'b0);
    apb(1'b1, tick_timer_pkg::IDX_TICK_CONTROL, 32'h0);
    wait_busy();
    apb(1'b1, tick_timer_pkg::IDX_TICK_IRQ_FLAGS, 32'h0);
    rd(tick_timer_pkg::IDX_TICK_IRQ_FLAGS, 32'h1, 1'b0);
    apb(1'b1, tick_timer_pkg::IDX_TICK_IRQ_ENABLE, 32'h1);
    // enable and irq both land on the edge that ends the write; irq is checked one edge later
    @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, tick_timer_pkg::IDX_TICK_IRQ_FLAGS, 32'h1);
    rd(tick_timer_pkg::IDX_TICK_IRQ_FLAGS, 32'h0, 1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, tick_timer_pkg::IDX_TICK_CONTROL, 32'h01);
    wait_busy();
    repeat (1200) @(posedge pclk);
    rd(tick_timer_pkg::IDX_TICK_IRQ_FLAGS, 32'h0, 1'b0);
    apb(1'b1, tick_timer_pkg::IDX_TICK_CONTROL, 32'h08);
    wait_busy();
    repeat (1200) @(posedge pclk);
    rd(tick_timer_pkg::IDX_TICK_IRQ_FLAGS, 32'h0, 1'b0);
    debug_halt <= 1'b1;
    apb(1'b1, tick_timer_pkg::IDX_TICK_CONTROL, 32'h09);
    wait_busy();
    repeat (600) @(posedge pclk);
    rd(tick_timer_pkg::IDX_TICK_IRQ_FLAGS, 32'h0, 1'b0);
    apb(1'b1, tick_timer_pkg::IDX_TICK_DEBUG_CONTROL, 32'h1);
    repeat (600) @(posedge pclk);
    rd(tick_timer_pkg::IDX_TICK_IRQ_FLAGS, 32'h1, 1'b0);
    rd(tick_timer_pkg::IDX_TICK_DEBUG_CONTROL, 32'h1, 1'b0);
    print_verdict();
  end
endmodule : tb_periodic_tick_timer
